// ===== inc/cpg_pkg.sv
// Constants for the codec PLL and gain control register bank.
// Assumes a 16-bit register word reached over the host serial port.
package cpg_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [5:0]  CPG_ADDR_PLL_INT  = 6'h1B;
	localparam logic [5:0]  CPG_ADDR_PLL_FRAC = 6'h1C;
	localparam logic [5:0]  CPG_ADDR_AC4      = 6'h1D;
	localparam logic [5:0]  CPG_ADDR_HS_GAIN  = 6'h1E;

	// ----------------------------------------------------------------
	// Field positions (low bit of each field)
	// ----------------------------------------------------------------
	localparam int          CPG_POS_PLL_ON    = 15;
	localparam int          CPG_POS_QVAL      = 11;
	localparam int          CPG_POS_PVAL      = 8;
	localparam int          CPG_POS_INT_MULT  = 2;
	localparam int          CPG_POS_FRAC      = 2;
	localparam int          CPG_POS_STEP_IN   = 15;
	localparam int          CPG_POS_STEP_DAC  = 14;
	localparam int          CPG_POS_STEP_ST   = 13;
	localparam int          CPG_POS_STEP_CP   = 12;
	localparam int          CPG_POS_STEP_BZ   = 11;
	localparam int          CPG_POS_HYST      = 9;
	localparam int          CPG_POS_HED_BIAS  = 7;
	localparam int          CPG_POS_HND_BIAS  = 6;
	localparam int          CPG_POS_SHORT     = 1;
	localparam int          CPG_POS_HS_MUTE   = 15;
	localparam int          CPG_POS_HS_GAIN   = 8;
	localparam int          CPG_POS_AGC_TGT   = 5;
	localparam int          CPG_POS_AGC_TC    = 1;
	localparam int          CPG_POS_AGC_ON    = 0;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [3:0]  CPG_RST_QVAL      = 4'h2;
	localparam logic [2:0]  CPG_RST_PVAL      = 3'h0;
	localparam logic [5:0]  CPG_RST_INT_MULT  = 6'h01;
	localparam logic [13:0] CPG_RST_FRAC      = 14'h0000;
	localparam logic [13:0] CPG_FRAC_MAX      = 14'h270F;
	localparam logic        CPG_RST_HS_MUTE   = 1'h1;
	localparam logic [6:0]  CPG_RST_HS_GAIN   = 7'h7F;
	localparam logic [2:0]  CPG_RST_AGC_TGT   = 3'h0;
	localparam logic [3:0]  CPG_RST_AGC_TC    = 4'h0;
	localparam logic [3:0]  CPG_RST_BZ_GAIN   = 4'hF;

	// ----------------------------------------------------------------
	// Serial frame: 16 command bits then 16 data bits
	// ----------------------------------------------------------------
	localparam logic [3:0]  CPG_LAST_BIT      = 4'hF;
	localparam int          CPG_CMD_READ_BIT  = 15;

endpackage : cpg_pkg

// ===== src/cpg_gain_ramp.sv
// Soft-stepping ramp for one gain stage, one code step per sample tick.
// Assumes tick is a one-cycle pulse at the reference sample rate.
`timescale 1ns/100ps
module cpg_gain_ramp
	import cpg_pkg::*;
#(
	parameter int         W   = 7,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] target,
	input  wire logic         step_off,
	input  wire logic         tick,
	output logic      [W-1:0] applied,
	output logic              settled
);

	typedef struct packed {
		logic [W-1:0] applied;
	} cpg_ramp_t;

	cpg_ramp_t st;
	cpg_ramp_t next_st;

	always_comb begin
		next_st = st;
		if (step_off) begin
			next_st.applied = target;
		end else if (tick) begin
			if (st.applied < target) begin
				next_st.applied = st.applied + W'(1);
			end else if (st.applied > target) begin
				next_st.applied = st.applied - W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.applied <= RST;
		end else begin
			st <= next_st;
		end
	end

	assign applied = st.applied;
	assign settled = (st.applied == target);

endmodule : cpg_gain_ramp

// ===== src/cpg_serial_port.sv
// Host serial port slave: 16-bit command then 16-bit data, mode 0.
// Assumes serial inputs are synchronous to clk and sclk is slower than clk/2.
`timescale 1ns/100ps
module cpg_serial_port
	import cpg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sclk,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	output logic      [5:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	input  wire logic [15:0] reg_rdata
);

	typedef enum logic [1:0] {
		CPG_SP_IDLE = 2'b00,
		CPG_SP_CMD  = 2'b01,
		CPG_SP_DATA = 2'b10,
		CPG_SP_WAIT = 2'b11
	} cpg_sp_state_t;

	typedef struct packed {
		cpg_sp_state_t state;
		logic          sclk_q;
		logic [3:0]    cnt;
		logic [15:0]   shreg;
		logic [15:0]   rd_sh;
		logic          is_read;
		logic          load;
		logic [5:0]    addr;
		logic          miso;
		logic          oe;
		logic          wr;
	} cpg_sp_t;

	cpg_sp_t st;
	cpg_sp_t next_st;
	logic    rise;
	logic    fall;

	always_comb begin
		next_st        = st;
		rise           = spi_sclk & ~st.sclk_q;
		fall           = ~spi_sclk & st.sclk_q;
		next_st.sclk_q = spi_sclk;
		next_st.wr     = 1'b0;
		next_st.load   = 1'b0;
		if (spi_cs_n) begin
			next_st.state = CPG_SP_IDLE;
			next_st.oe    = 1'b0;
		end else begin
			unique case (st.state)
				CPG_SP_IDLE: begin
					next_st.state = CPG_SP_CMD;
					next_st.cnt   = 4'h0;
				end
				CPG_SP_CMD: begin
					if (rise) begin
						next_st.shreg = {st.shreg[14:0], spi_mosi};
						next_st.cnt   = st.cnt + 4'h1;
						if (st.cnt == CPG_LAST_BIT) begin
							next_st.is_read = st.shreg[CPG_CMD_READ_BIT-1];
							next_st.addr    = {st.shreg[4:0], spi_mosi};
							next_st.load    = 1'b1;
							next_st.state   = CPG_SP_DATA;
						end
					end
				end
				CPG_SP_DATA: begin
					if (st.load && st.is_read) begin
						next_st.rd_sh = reg_rdata;
						next_st.miso  = reg_rdata[15];
						next_st.oe    = 1'b1;
					end else if (fall && st.is_read) begin
						// First fall re-presents bit 15 so it stands before the first data rise
						next_st.rd_sh = {st.rd_sh[14:0], 1'b0};
						next_st.miso  = st.rd_sh[15];
					end
					if (rise) begin
						next_st.shreg = {st.shreg[14:0], spi_mosi};
						next_st.cnt   = st.cnt + 4'h1;
						if (st.cnt == CPG_LAST_BIT) begin
							next_st.wr    = ~st.is_read;
							next_st.state = CPG_SP_WAIT;
						end
					end
				end
				CPG_SP_WAIT: begin
					// Extra clocks after a frame are ignored until deselect
					next_st.state = CPG_SP_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.state   <= CPG_SP_IDLE;
			st.sclk_q  <= 1'b0;
			st.cnt     <= 4'h0;
			st.shreg   <= 16'h0000;
			st.rd_sh   <= 16'h0000;
			st.is_read <= 1'b0;
			st.load    <= 1'b0;
			st.addr    <= 6'h00;
			st.miso    <= 1'b0;
			st.oe      <= 1'b0;
			st.wr      <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign spi_miso    = st.miso;
	assign spi_miso_oe = st.oe;
	assign reg_addr    = st.addr;
	assign reg_wdata   = st.shreg;
	assign reg_wr      = st.wr;

endmodule : cpg_serial_port

// ===== src/cpg_regs.sv
// Codec PLL multiplier, soft-stepping, bias and handset gain register bank.
// Assumes fs_ref_tick pulses once per reference sample period and that the
// short-circuit detector and AGC loop sit outside, synchronous to clk.
//
// Summary of operation
// - Six-bit integer multiplier, zero invalid, resets one
// - Fraction 0..9999, larger values act as 9999
// - PLL register low two bits read zero
// - Five step-off bits, zero steps, reset zero
// - Sidetone and cellphone step 0.5 dB per tick
// - Buzzer steps 3 dB per tick
// - Hysteresis 1/2/4/none, only with AGC
// - Headset and handset bias voltage selects
// - Audio control reserved bits read zero
// - Read-only headphone short-circuit flag, resets zero
// - Handset mute bit, resets muted
// - Handset gain 0.5 dB per code, resets max
// - AGC active: gain readback as signed value
// - Three-bit AGC target level, resets zero
// - Four-bit AGC time constant, resets zero
// - AGC enable hands gain stage to AGC while the handset input is selected
// - PLL enable gates multiplier valid flag; integer multiplier goes out raw, fraction clamped to 9999
`timescale 1ns/100ps
module cpg_regs
	import cpg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Host serial port
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sclk,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	// Sample timing and analog status
	input  wire logic        fs_ref_tick,
	input  wire logic        headphone_short,
	input  wire logic        handset_selected,
	input  wire logic [7:0]  agc_applied_gain,
	// Gain targets owned by neighbouring registers
	input  wire logic [6:0]  sidetone_gain_target,
	input  wire logic [6:0]  cellphone_gain_target,
	input  wire logic [3:0]  buzzer_gain_target,
	// PLL controls
	output logic             pll_on,
	output logic      [3:0]  pll_q_div,
	output logic      [2:0]  pll_p_div,
	output logic      [5:0]  pll_int_mult,
	output logic      [13:0] pll_frac_mult,
	output logic             pll_mult_valid,
	// Stepping controls and applied gains
	output logic             input_gain_step_off,
	output logic             dac_gain_step_off,
	output logic      [6:0]  sidetone_gain_applied,
	output logic      [6:0]  cellphone_gain_applied,
	output logic      [3:0]  buzzer_gain_applied,
	output logic             cellphone_gain_settled,
	// Microphone AGC and bias
	output logic      [2:0]  agc_hysteresis_db,
	output logic      [1:0]  headset_bias_out,
	output logic             handset_bias_out,
	// Handset gain stage
	output logic             handset_mute,
	output logic      [7:0]  handset_pga_gain,
	output logic             handset_agc_on,
	output logic      [2:0]  handset_agc_target,
	output logic      [3:0]  handset_agc_timeconst
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [13:0] cpg_clamp_frac(input logic [13:0] v);
		cpg_clamp_frac = (v > CPG_FRAC_MAX) ? CPG_FRAC_MAX : v;
	endfunction : cpg_clamp_frac

	function automatic logic [2:0] cpg_hyst_db(input logic [1:0] code);
		unique case (code)
			2'h0:    cpg_hyst_db = 3'h1;
			2'h1:    cpg_hyst_db = 3'h2;
			2'h2:    cpg_hyst_db = 3'h4;
			default: cpg_hyst_db = 3'h0;
		endcase
	endfunction : cpg_hyst_db

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        pll_on;
		logic [3:0]  q_val;
		logic [2:0]  p_val;
		logic [5:0]  int_mult;
		logic [13:0] frac;
		logic        step_in;
		logic        step_dac;
		logic        step_st;
		logic        step_cp;
		logic        step_bz;
		logic [1:0]  hyst;
		logic [1:0]  hed_bias;
		logic        hnd_bias;
		logic        short_flag;
		logic        hs_mute;
		logic [6:0]  hs_gain;
		logic [2:0]  agc_tgt;
		logic [3:0]  agc_tc;
		logic        agc_on;
		logic [13:0] frac_eff;
		logic [7:0]  hs_pga;
		logic [2:0]  hyst_db;
		logic [1:0]  hed_bias_v;
	} cpg_regs_t;

	cpg_regs_t   st;
	cpg_regs_t   next_st;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic [15:0] reg_rdata;
	logic [6:0]  hs_ramp;
	logic        agc_owns;

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	cpg_serial_port u_port (
		.clk         (clk),
		.rst_n       (rst_n),
		.spi_cs_n    (spi_cs_n),
		.spi_sclk    (spi_sclk),
		.spi_mosi    (spi_mosi),
		.spi_miso    (spi_miso),
		.spi_miso_oe (spi_miso_oe),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rdata   (reg_rdata)
	);

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	// Gain fields belong to the AGC only while the handset input is selected
	assign agc_owns = st.agc_on & handset_selected;

	// Reserved, unmapped and unwritten bits fall out of the zero default
	always_comb begin
		reg_rdata = 16'h0000;
		unique case (reg_addr)
			CPG_ADDR_PLL_INT: begin
				reg_rdata[CPG_POS_PLL_ON]                   = st.pll_on;
				reg_rdata[CPG_POS_QVAL +: 4]                = st.q_val;
				reg_rdata[CPG_POS_PVAL +: 3]                = st.p_val;
				reg_rdata[CPG_POS_INT_MULT +: 6]            = st.int_mult;
			end
			CPG_ADDR_PLL_FRAC: begin
				reg_rdata[CPG_POS_FRAC +: 14]               = st.frac;
			end
			CPG_ADDR_AC4: begin
				reg_rdata[CPG_POS_STEP_IN]                  = st.step_in;
				reg_rdata[CPG_POS_STEP_DAC]                 = st.step_dac;
				reg_rdata[CPG_POS_STEP_ST]                  = st.step_st;
				reg_rdata[CPG_POS_STEP_CP]                  = st.step_cp;
				reg_rdata[CPG_POS_STEP_BZ]                  = st.step_bz;
				reg_rdata[CPG_POS_HYST +: 2]                = st.hyst;
				reg_rdata[CPG_POS_HED_BIAS +: 2]            = st.hed_bias;
				reg_rdata[CPG_POS_HND_BIAS]                 = st.hnd_bias;
				reg_rdata[CPG_POS_SHORT]                    = st.short_flag;
			end
			CPG_ADDR_HS_GAIN: begin
				if (agc_owns) begin
					reg_rdata[CPG_POS_HS_GAIN +: 8]         = agc_applied_gain;
				end else begin
					reg_rdata[CPG_POS_HS_MUTE]              = st.hs_mute;
					reg_rdata[CPG_POS_HS_GAIN +: 7]         = st.hs_gain;
				end
				reg_rdata[CPG_POS_AGC_TGT +: 3]             = st.agc_tgt;
				reg_rdata[CPG_POS_AGC_TC +: 4]              = st.agc_tc;
				reg_rdata[CPG_POS_AGC_ON]                   = st.agc_on;
			end
			default: begin
				reg_rdata = 16'h0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	// A cut frame never pulses reg_wr, so a partial word never lands
	always_comb begin
		next_st            = st;
		// Detector level follows the headphone_short input; software cannot touch it
		next_st.short_flag = headphone_short;
		if (reg_wr) begin
			unique case (reg_addr)
				CPG_ADDR_PLL_INT: begin
					next_st.pll_on   = reg_wdata[CPG_POS_PLL_ON];
					next_st.q_val    = reg_wdata[CPG_POS_QVAL +: 4];
					next_st.p_val    = reg_wdata[CPG_POS_PVAL +: 3];
					next_st.int_mult = reg_wdata[CPG_POS_INT_MULT +: 6];
				end
				CPG_ADDR_PLL_FRAC: begin
					next_st.frac     = reg_wdata[CPG_POS_FRAC +: 14];
				end
				CPG_ADDR_AC4: begin
					next_st.step_in  = reg_wdata[CPG_POS_STEP_IN];
					next_st.step_dac = reg_wdata[CPG_POS_STEP_DAC];
					next_st.step_st  = reg_wdata[CPG_POS_STEP_ST];
					next_st.step_cp  = reg_wdata[CPG_POS_STEP_CP];
					next_st.step_bz  = reg_wdata[CPG_POS_STEP_BZ];
					next_st.hyst     = reg_wdata[CPG_POS_HYST +: 2];
					next_st.hed_bias = reg_wdata[CPG_POS_HED_BIAS +: 2];
					next_st.hnd_bias = reg_wdata[CPG_POS_HND_BIAS];
				end
				CPG_ADDR_HS_GAIN: begin
					// While the AGC owns the stage the gain fields are read-only
					if (!agc_owns) begin
						next_st.hs_mute = reg_wdata[CPG_POS_HS_MUTE];
						next_st.hs_gain = reg_wdata[CPG_POS_HS_GAIN +: 7];
					end
					next_st.agc_tgt  = reg_wdata[CPG_POS_AGC_TGT +: 3];
					next_st.agc_tc   = reg_wdata[CPG_POS_AGC_TC +: 4];
					next_st.agc_on   = reg_wdata[CPG_POS_AGC_ON];
				end
				default: begin
					next_st = next_st;
				end
			endcase
		end
		// Derived outputs, registered so the analog side sees clean levels
		// Clamp on the way out so readback returns what was written
		next_st.frac_eff   = cpg_clamp_frac(next_st.frac);
		next_st.hyst_db    = next_st.agc_on ? cpg_hyst_db(next_st.hyst) : 3'h0;
		next_st.hed_bias_v = {next_st.hed_bias[1], next_st.hed_bias[0] & ~next_st.hed_bias[1]};
		// Manual path keeps bit 7 clear; only the AGC reaches negative codes
		if (agc_owns) begin
			next_st.hs_pga = agc_applied_gain;
		end else begin
			next_st.hs_pga = {1'b0, hs_ramp};
		end
	end

	// Derived fields reset to what their decode of the reset fields gives
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.pll_on     <= 1'b0;
			st.q_val      <= CPG_RST_QVAL;
			st.p_val      <= CPG_RST_PVAL;
			st.int_mult   <= CPG_RST_INT_MULT;
			st.frac       <= CPG_RST_FRAC;
			st.step_in    <= 1'b0;
			st.step_dac   <= 1'b0;
			st.step_st    <= 1'b0;
			st.step_cp    <= 1'b0;
			st.step_bz    <= 1'b0;
			st.hyst       <= 2'h0;
			st.hed_bias   <= 2'h0;
			st.hnd_bias   <= 1'b0;
			st.short_flag <= 1'b0;
			st.hs_mute    <= CPG_RST_HS_MUTE;
			st.hs_gain    <= CPG_RST_HS_GAIN;
			st.agc_tgt    <= CPG_RST_AGC_TGT;
			st.agc_tc     <= CPG_RST_AGC_TC;
			st.agc_on     <= 1'b0;
			st.frac_eff   <= CPG_RST_FRAC;
			st.hs_pga     <= {1'b0, CPG_RST_HS_GAIN};
			st.hyst_db    <= 3'h0;
			st.hed_bias_v <= 2'h0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Gain ramps
	// ----------------------------------------------------------------
	cpg_gain_ramp #(.W(7), .RST(CPG_RST_HS_GAIN)) u_hs_ramp (
		.clk      (clk),
		.rst_n    (rst_n),
		.target   (st.hs_gain),
		.step_off (st.step_in),
		.tick     (fs_ref_tick),
		.applied  (hs_ramp),
		.settled  ()
	);

	// Targets live in neighbouring registers; only the step timing is here
	cpg_gain_ramp #(.W(7), .RST(7'h00)) u_st_ramp (
		.clk      (clk),
		.rst_n    (rst_n),
		.target   (sidetone_gain_target),
		.step_off (st.step_st),
		.tick     (fs_ref_tick),
		.applied  (sidetone_gain_applied),
		.settled  ()
	);

	cpg_gain_ramp #(.W(7), .RST(7'h00)) u_cp_ramp (
		.clk      (clk),
		.rst_n    (rst_n),
		.target   (cellphone_gain_target),
		.step_off (st.step_cp),
		.tick     (fs_ref_tick),
		.applied  (cellphone_gain_applied),
		.settled  (cellphone_gain_settled)
	);

	// One buzzer code is 3 dB, so a code step per tick is the full step
	cpg_gain_ramp #(.W(4), .RST(CPG_RST_BZ_GAIN)) u_bz_ramp (
		.clk      (clk),
		.rst_n    (rst_n),
		.target   (buzzer_gain_target),
		.step_off (st.step_bz),
		.tick     (fs_ref_tick),
		.applied  (buzzer_gain_applied),
		.settled  ()
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Stored integer code goes out raw; the valid flag marks the zero code
	assign pll_on                = st.pll_on;
	assign pll_q_div             = st.q_val;
	assign pll_p_div             = st.p_val;
	assign pll_int_mult          = st.int_mult;
	assign pll_frac_mult         = st.frac_eff;
	assign pll_mult_valid        = st.pll_on & (st.int_mult != 6'h00);
	assign input_gain_step_off   = st.step_in;
	assign dac_gain_step_off     = st.step_dac;
	assign agc_hysteresis_db     = st.hyst_db;
	assign headset_bias_out      = st.hed_bias_v;
	assign handset_bias_out      = st.hnd_bias;
	assign handset_mute          = st.hs_mute;
	assign handset_pga_gain      = st.hs_pga;
	assign handset_agc_on        = st.agc_on;
	assign handset_agc_target    = st.agc_tgt;
	assign handset_agc_timeconst = st.agc_tc;

endmodule : cpg_regs

// ===== bench/cpg_host_model.sv
// Host processor model driving the serial control port as master.
// Assumes clk is the block clock; all pins change just after its rising edge.
`timescale 1ns/100ps
module cpg_host_model (
	input  wire logic clk,
	output logic      spi_cs_n,
	output logic      spi_sclk,
	output logic      spi_mosi,
	input  wire logic spi_miso,
	input  wire logic spi_miso_oe
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
	end
	// Fewer than 32 bits gives a frame cut short
	task automatic xfer(input logic [15:0] c, input logic [15:0] d, input int n, output logic [15:0] r);
		logic [31:0] f;
		f = {c, d};
		r = '0;
		@(posedge clk) spi_cs_n <= 1'b0;
		for (int i = 31; i > 31 - n; i--) begin
			@(posedge clk) spi_mosi <= f[i];
			repeat (2) @(posedge clk);
			spi_sclk <= 1'b1;
			// Undriven line shows the inverse of the last bit
			if (i < 16) r = {r[14:0], spi_miso_oe ? spi_miso : ~r[0]};
			repeat (3) @(posedge clk);
			spi_sclk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		repeat (4) @(posedge clk);
		#1;
	endtask : xfer
endmodule : cpg_host_model

// ===== bench/cpg_regs_sva.sv
// Checker for the register bank, watching top-level ports only.
// Assumes one clk domain with synchronous active-low rst_n.
`timescale 1ns/100ps
module cpg_regs_sva (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        spi_cs_n,
	input wire logic        handset_selected,
	input wire logic [7:0]  agc_applied_gain,
	input wire logic        pll_on,
	input wire logic [5:0]  pll_int_mult,
	input wire logic [13:0] pll_frac_mult,
	input wire logic        pll_mult_valid,
	input wire logic [2:0]  agc_hysteresis_db,
	input wire logic [1:0]  headset_bias_out,
	input wire logic        handset_mute,
	input wire logic [7:0]  handset_pga_gain,
	input wire logic        handset_agc_on,
	input wire logic [2:0]  handset_agc_target
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_cs_idle;
		spi_cs_n [*3];
	endsequence
	sequence s_agc_held;
		handset_agc_on && handset_selected && $past(handset_agc_on && handset_selected);
	endsequence
	a_mult_valid: assert property (pll_mult_valid == (pll_on && pll_int_mult != 6'h00))
		else $error("multiplier valid flag wrong");
	a_frac_clamp: assert property (pll_frac_mult <= 14'h270F)
		else $error("fraction above limit");
	a_hyst_off: assert property (!handset_agc_on && !$past(handset_agc_on) |-> agc_hysteresis_db == 3'h0)
		else $error("hysteresis without agc");
	a_hyst_codes: assert property (agc_hysteresis_db inside {3'h0, 3'h1, 3'h2, 3'h4})
		else $error("hysteresis value illegal");
	a_bias_range: assert property (headset_bias_out != 2'h3)
		else $error("headset bias code illegal");
	a_pga_agc: assert property (s_agc_held and $stable(agc_applied_gain) |-> handset_pga_gain == agc_applied_gain)
		else $error("pga not following agc");
	a_pga_manual: assert property (!handset_agc_on && !$past(handset_agc_on) |-> !handset_pga_gain[7])
		else $error("manual gain out of range");
	a_idle_hold: assert property (s_cs_idle |-> $stable({pll_on, pll_int_mult, headset_bias_out, handset_agc_target}))
		else $error("register changed without access");
	a_reset_vals: assert property (disable iff (1'b0) !rst_n |=> !pll_on && pll_int_mult == 6'h01
		&& pll_frac_mult == 14'h0000 && handset_mute && handset_pga_gain == 8'h7F && handset_agc_target == 3'h0)
		else $error("reset values wrong");
endmodule : cpg_regs_sva
bind cpg_regs cpg_regs_sva u_sva (.*);

// ===== bench/tb.sv
// Self-checking bench for the register bank behind the serial port.
// Assumes the host model as serial master and a 250 MHz clk.
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module tb import cpg_pkg::*;;
	logic        clk, rst_n, fs_ref_tick, headphone_short, handset_selected, handset_mute, handset_agc_on;
	logic        spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, pll_on, pll_mult_valid;
	logic        input_gain_step_off, dac_gain_step_off, cellphone_gain_settled, handset_bias_out;
	logic [1:0]  headset_bias_out;
	logic [2:0]  pll_p_div, agc_hysteresis_db, handset_agc_target;
	logic [3:0]  pll_q_div, buzzer_gain_target, buzzer_gain_applied, handset_agc_timeconst;
	logic [5:0]  pll_int_mult;
	logic [6:0]  sidetone_gain_target, cellphone_gain_target, sidetone_gain_applied, cellphone_gain_applied;
	logic [7:0]  agc_applied_gain, handset_pga_gain;
	logic [13:0] pll_frac_mult;
	logic [15:0] rdat;
	int          fails, n_checks;
	cpg_host_model u_host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
	cpg_regs u_dut (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		u_host.xfer({10'h000, a}, d, 32, rdat);
	endtask : wr
	task automatic chk_rd(input logic [5:0] a, input logic [15:0] e);
		u_host.xfer({10'h200, a}, 16'h0000, 32, rdat);
		`CHK(rdat, e)
	endtask : chk_rd
	task automatic tick;
		@(posedge clk) fs_ref_tick <= 1'b1;
		@(posedge clk) fs_ref_tick <= 1'b0;
		cyc(2);
	endtask : tick
	task automatic finish_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		`CHK({pll_on, pll_q_div, pll_p_div, pll_int_mult, pll_frac_mult}, {1'b0, 4'h2, 3'h0, 6'h01, 14'h0000})
		`CHK({handset_mute, handset_pga_gain, handset_agc_target, handset_agc_timeconst}, 16'hBF80)
		`CHK({input_gain_step_off, dac_gain_step_off, headset_bias_out, handset_bias_out}, 5'h00)
		chk_rd(CPG_ADDR_PLL_INT, 16'h1004);
		chk_rd(CPG_ADDR_PLL_FRAC, 16'h0000);
		chk_rd(CPG_ADDR_AC4, 16'h0000);
		chk_rd(CPG_ADDR_HS_GAIN, 16'hFF00);
	endtask : t_reset
	task automatic t_pll;
		logic [15:0] w[4] = '{16'h9C38, 16'h9C3C, 16'h9C40, 16'hFFFF};
		logic [13:0] e[4] = '{14'h270E, 14'h270F, 14'h270F, 14'h270F};
		wr(CPG_ADDR_PLL_INT, 16'h8003);
		`CHK({pll_on, pll_int_mult, pll_mult_valid}, 8'h80)
		chk_rd(CPG_ADDR_PLL_INT, 16'h8000);
		wr(CPG_ADDR_PLL_INT, 16'h90FC);
		`CHK({pll_int_mult, pll_mult_valid}, 7'h7F)
		wr(CPG_ADDR_PLL_INT, 16'h10FC);
		`CHK(pll_mult_valid, 1'b0)
		for (int i = 0; i < 4; i++) begin
			wr(CPG_ADDR_PLL_FRAC, w[i]);
			`CHK(pll_frac_mult, e[i])
		end
		chk_rd(CPG_ADDR_PLL_FRAC, 16'hFFFC);
	endtask : t_pll
	task automatic t_ctrl;
		logic [2:0] hy[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
		logic [1:0] hb[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
		@(posedge clk) headphone_short <= 1'b1;
		wr(CPG_ADDR_AC4, 16'hFFFF);
		`CHK({input_gain_step_off, dac_gain_step_off, headset_bias_out, handset_bias_out}, 5'h1D)
		`CHK(agc_hysteresis_db, 3'h0)
		chk_rd(CPG_ADDR_AC4, 16'hFFC2);
		wr(CPG_ADDR_HS_GAIN, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			wr(CPG_ADDR_AC4, {5'h00, 2'(i), 2'(i), 1'(i), 6'h00});
			`CHK({agc_hysteresis_db, headset_bias_out, handset_bias_out}, {hy[i], hb[i], 1'(i)})
		end
		@(posedge clk) headphone_short <= 1'b0;
		cyc(2);
		chk_rd(CPG_ADDR_AC4, 16'h07C0);
	endtask : t_ctrl
	task automatic t_ramp;
		@(posedge clk) begin
			sidetone_gain_target <= 7'h0A;
			cellphone_gain_target <= 7'h02;
			buzzer_gain_target <= 4'hC;
		end
		cyc(3);
		`CHK({sidetone_gain_applied, buzzer_gain_applied}, 11'h00F)
		tick();
		`CHK({sidetone_gain_applied, cellphone_gain_applied, buzzer_gain_applied, cellphone_gain_settled}, 19'h0103C)
		tick();
		tick();
		`CHK({sidetone_gain_applied, cellphone_gain_applied, buzzer_gain_applied, cellphone_gain_settled}, 19'h03059)
		wr(CPG_ADDR_AC4, 16'hB800);
		`CHK({input_gain_step_off, dac_gain_step_off, sidetone_gain_applied}, 9'h10A)
		@(posedge clk) begin
			cellphone_gain_target <= 7'h40;
			buzzer_gain_target <= 4'h3;
		end
		cyc(2);
		`CHK({cellphone_gain_applied, buzzer_gain_applied}, 11'h403)
	endtask : t_ramp
	task automatic t_hs;
		wr(CPG_ADDR_HS_GAIN, 16'h05F4);
		`CHK({handset_mute, handset_pga_gain, handset_agc_target, handset_agc_timeconst}, 16'h02FA)
		@(posedge clk) begin
			handset_selected <= 1'b1;
			agc_applied_gain <= 8'hE8;
		end
		wr(CPG_ADDR_HS_GAIN, 16'h05F5);
		`CHK({handset_agc_on, handset_pga_gain}, 9'h1E8)
		wr(CPG_ADDR_HS_GAIN, 16'h7FF5);
		chk_rd(CPG_ADDR_HS_GAIN, 16'hE8F5);
		@(posedge clk) agc_applied_gain <= 8'h77;
		cyc(3);
		`CHK(handset_pga_gain, 8'h77)
		@(posedge clk) handset_selected <= 1'b0;
		cyc(3);
		`CHK(handset_pga_gain, 8'h05)
	endtask : t_hs
	task automatic t_cut;
		u_host.xfer({10'h000, CPG_ADDR_PLL_INT}, 16'h0000, 20, rdat);
		`CHK(pll_int_mult, 6'h3F)
		chk_rd(6'h05, 16'h0000);
	endtask : t_cut
	initial begin
		{rst_n, fs_ref_tick, headphone_short, handset_selected} = 4'h0;
		{sidetone_gain_target, cellphone_gain_target, buzzer_gain_target} = 18'h0000F;
		agc_applied_gain = 8'h00;
		fails = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_pll();
		t_ctrl();
		t_ramp();
		t_hs();
		t_cut();
		finish_test();
	end
	initial begin
		#200000;
		fails++;
		finish_test();
	end
endmodule : tb
